// file: tb_top.sv
/* Self-checking bench for the control request handler.
   Assumes the host model beside it and a shortened millisecond tick. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic recovery_start, high_speed, setup_byte_valid, setup_ack_sent, in_pkt_sent, out_pkt_rcvd;
   logic status_done, token_valid, accept_xfer, addr_match, speed_hs, req_valid, status_ready;
   logic stall_data, stall_status, overrun;
   logic [7:0] setup_byte;
   logic [10:0] in_pkt_len;
   logic [6:0] token_addr, dev_addr;
   logic [15:0] in_allow;
   int num_errors = 0;
   int check_count = 0;

   ucrh_top #(.TICK_CYCLES(TICK), .MAX_PKT(64)) i_ucrh_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .recovery_start,
      .high_speed, .setup_byte_valid, .setup_byte, .setup_ack_sent, .in_pkt_sent, .in_pkt_len,
      .out_pkt_rcvd, .status_done, .token_valid, .token_addr, .accept_xfer, .addr_match, .dev_addr,
      .speed_hs, .req_valid, .status_ready, .stall_data, .stall_status, .in_allow, .overrun);
   ucrh_host i_ucrh_host (.hclk, .recovery_start, .high_speed, .setup_byte_valid, .setup_byte,
      .setup_ack_sent, .in_pkt_sent, .in_pkt_len, .out_pkt_rcvd, .status_done, .token_valid, .token_addr);

   // The 25 MHz clock.
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Single AHB-Lite word transfer; the wait ends only on hready or the watchdog.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   // Verdict and end of run.
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Recovery restarts on the event; speed is latched with it.
   task automatic t_recovery();
      i_ucrh_host.strobe(0, 11'h000);
      repeat (30) @(posedge hclk);
      check("accept early", accept_xfer, 0);
      repeat (18) @(posedge hclk);
      check("accept late", accept_xfer, 1);
      check("speed", speed_hs, 1);
      ahb(0, ucrh_pkg::A_CONFIG, 0, rd);
      check("config", rd, 32'h0200_0000);
      check("hresp", hresp, 0);
   endtask

   // Address assignment: status refused before done, address moves after status.
   task automatic t_set_address();
      i_ucrh_host.send_setup(64'h0000_0000_002a_0500);
      #1 check("req_valid", req_valid, 1);
      i_ucrh_host.strobe(2, 11'h000);
      #1 check("early status", dev_addr, 0);
      ahb(1, ucrh_pkg::A_CTRL, 32'h0000_0001, rd);
      repeat (2) @(posedge hclk);
      check("status_ready", status_ready, 1);
      check("old addr", dev_addr, 0);
      i_ucrh_host.strobe(2, 11'h000);
      #1 check("new addr", dev_addr, 7'h2a);
      i_ucrh_host.strobe(3, 11'h02a);
      #1 check("match new", addr_match, 1);
      i_ucrh_host.strobe(3, 11'h000);
      #1 check("match old", addr_match, 0);
   endtask

   // IN request: field packing and the byte allowance.
   task automatic t_in();
      i_ucrh_host.send_setup(64'h0064_0000_0100_0680);
      ahb(0, ucrh_pkg::A_SETUP_LO, 0, rd);
      check("setup lo", rd, 32'h0100_0680);
      ahb(0, ucrh_pkg::A_SETUP_HI, 0, rd);
      check("setup hi", rd, 32'h0064_0000);
      ahb(1, ucrh_pkg::A_CTRL, 32'h0000_0001, rd);
      repeat (2) @(posedge hclk);
      check("allow", in_allow, 16'h0064);
      i_ucrh_host.strobe(1, 11'h040);
      #1 check("allow 64", in_allow, 16'h0024);
      i_ucrh_host.strobe(1, 11'h024);
      #1 check("allow 0", in_allow, 16'h0000);
      i_ucrh_host.strobe(2, 11'h000);
   endtask

   // A no-data request left unfinished runs over its deadline.
   task automatic t_overrun();
      i_ucrh_host.send_setup(64'h0000_0000_0001_0900);
      repeat (40 * TICK) @(posedge hclk);
      check("no overrun", overrun, 0);
      repeat (20 * TICK) @(posedge hclk);
      check("overrun", overrun, 1);
      ahb(1, ucrh_pkg::A_CTRL, 32'h0000_0001, rd);
      i_ucrh_host.strobe(2, 11'h000);
      ahb(1, ucrh_pkg::A_STATUS, 32'h0000_0100, rd);
      repeat (2) @(posedge hclk);
      check("overrun clear", overrun, 0);
   endtask

   // Request errors stall; valid kinds and the dual-speed reads do not.
   task automatic t_stall();
      logic [63:0] req [7] = '{64'h0000_0000_0000_0060, 64'h0000_0000_0000_0004,
         64'h0012_0000_0700_0680, 64'h0000_0000_0000_0903, 64'h0000_0000_0000_0921,
         64'h0000_0000_0001_0980, 64'h0012_0000_0700_0680};
      logic exp [7] = '{1, 1, 1, 0, 0, 0, 0};
      for (int i = 0; i < 7; i++) begin
         if (i == 6) ahb(1, ucrh_pkg::A_CONFIG, 32'h0200_0001, rd);
         i_ucrh_host.send_setup(req[i]);
         #1 check("stall", stall_data | stall_status, exp[i]);
      end
      ahb(1, ucrh_pkg::A_CONFIG, 32'h0110_0001, rd);
      i_ucrh_host.send_setup(req[6]);
      #1 check("old version", stall_data, 1);
   endtask

   // OUT request rejected by firmware mid-stage: the data stage stalls.
   task automatic t_out();
      i_ucrh_host.send_setup(64'h0002_0000_0000_0700);
      #1 check("out req", req_valid, 1);
      i_ucrh_host.strobe(4, 11'h000);
      ahb(1, ucrh_pkg::A_CTRL, 32'h0000_0002, rd);
      #1 check("out stall", {stall_data, stall_status}, 2'b10);
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1 check("reset accept", accept_xfer, 0);
      check("reset addr", dev_addr, 0);
      t_recovery();
      t_set_address();
      t_in();
      t_overrun();
      t_stall();
      t_out();
      report_and_stop();
   end

   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      report_and_stop();
   end
endmodule

// file: ucrh_host.sv
/* Host controller model for the control request handler.
   Assumes the bench's clock; events change just after a rising edge. */
module ucrh_host (
   // Clock.
   input wire logic hclk,
   // Bus state.
   output logic recovery_start,
   output logic high_speed,
   // Setup stage.
   output logic setup_byte_valid,
   output logic [7:0] setup_byte,
   output logic setup_ack_sent,
   // Data, status and tokens.
   output logic in_pkt_sent,
   output logic [10:0] in_pkt_len,
   output logic out_pkt_rcvd,
   output logic status_done,
   output logic token_valid,
   output logic [6:0] token_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle lines carry inverted data, so stale values never pass as fresh ones.
   initial begin
      {recovery_start, setup_byte_valid, setup_ack_sent, in_pkt_sent} = '0;
      {out_pkt_rcvd, status_done, token_valid} = '0;
      high_speed = 1'b1;
      setup_byte = 8'h5a;
      in_pkt_len = 11'h2a5;
      token_addr = 7'h55;
   end
   // Eight setup bytes, byte 0 first, then the acknowledge pulse.
   task automatic send_setup(input logic [63:0] s);
      for (int i = 0; i < 8; i++) begin
         @(posedge hclk);
         setup_byte_valid <= 1'b1;
         setup_byte <= s[i*8 +: 8];
      end
      @(posedge hclk);
      setup_byte_valid <= 1'b0;
      setup_byte <= ~s[63:56];
      @(posedge hclk);
      setup_ack_sent <= 1'b1;
      @(posedge hclk);
      setup_ack_sent <= 1'b0;
   endtask
   // One-cycle event: 0 recovery, 1 IN packet, 2 status, 3 token, else OUT.
   task automatic strobe(input int k, input logic [10:0] v);
      @(posedge hclk);
      case (k)
         0: recovery_start <= 1'b1;
         1: in_pkt_sent <= 1'b1;
         2: status_done <= 1'b1;
         3: token_valid <= 1'b1;
         default: out_pkt_rcvd <= 1'b1;
      endcase
      in_pkt_len <= v;
      token_addr <= v[6:0];
      @(posedge hclk);
      {recovery_start, in_pkt_sent, status_done, token_valid, out_pkt_rcvd} <= '0;
      in_pkt_len <= ~v;
      token_addr <= ~v[6:0];
   endtask
endmodule

// file: ucrh_pkg.sv
/*
 * Shared constants for the control request handler: register map, field
 * positions, reset values, request decoding codes and deadline figures.
 * Assumes a single 25 MHz system clock; all deadlines are counted in
 * millisecond ticks derived from that clock.
 */
package ucrh_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] A_SETUP_LO = 8'h00;
   localparam logic [7:0] A_SETUP_HI = 8'h04;
   localparam logic [7:0] A_CTRL = 8'h08;
   localparam logic [7:0] A_CONFIG = 8'h0C;
   localparam logic [7:0] A_STATUS = 8'h10;

   // Control word bits.
   localparam int CTRL_DONE = 0;
   localparam int CTRL_ERR = 1;
   // Config word fields.
   localparam int CFG_DUAL = 0;
   localparam int CFG_BCD_LSB = 16;
   localparam logic [15:0] BCD_RESET = 16'h0200;
   localparam logic [15:0] BCD_DUAL = 16'h0200;
   // Status word fields.
   localparam int ST_HS = 4;
   localparam int ST_REC = 5;
   localparam int ST_STALLD = 6;
   localparam int ST_STALLS = 7;
   localparam int ST_OVR = 8;
   localparam int ST_ADDR_LSB = 16;

   // ----------------------------------------------------------------
   // Setup request decoding
   // ----------------------------------------------------------------
   localparam logic [1:0] TYPE_STD = 2'h0;
   localparam logic [1:0] TYPE_RSVD = 2'h3;
   localparam logic [4:0] RCPT_MAX = 5'h03;
   localparam logic [7:0] REQ_SET_ADDR = 8'h05;
   localparam logic [7:0] REQ_GET_DESC = 8'h06;
   localparam logic [7:0] DESC_QUAL = 8'h06;
   localparam logic [7:0] DESC_OTHER = 8'h07;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int MS_NS = 1_000_000;
   localparam int TICK_CYCLES = MS_NS / CLK_NS;
   localparam logic [12:0] T_RECOV_MS = 13'h000A;
   localparam logic [12:0] T_NODATA_MS = 13'h0032;
   localparam logic [12:0] T_IN_PKT_MS = 13'h01F4;
   localparam logic [12:0] T_STATUS_MS = 13'h0032;
   localparam logic [12:0] T_OUT_MS = 13'h1388;
   localparam int MAX_PKT = 64;

   typedef enum logic [2:0] {S_IDLE, S_RECOV, S_WAIT_ACK, S_PROC, S_DIN, S_DOUT, S_STATUS} ucrh_state_t;

endpackage

// file: ucrh_top.sv
/*
 * Control request handler for the default control pipe of a device.
 * Collects the eight setup bytes, decodes them, paces firmware through
 * the request, guards the deadlines, stalls bad requests and owns the
 * device address. Registers are reached over AHB-Lite.
 * Assumes the serial engine beside it delivers setup bytes and packet
 * events as one-cycle pulses synchronous to hclk.
 */
// Implementation choices: the register addresses and register access over AHB-Lite.

// How it works
// [R1] Work on a request starts once the setup handshake has gone out.
// [R2] Status stage is only offered once firmware has marked the request done.
// [R3] Long operations are marked done when started; completion is signalled elsewhere.
// [R4] No request may run past five seconds; overruns raise a sticky flag.
// [R5] Host waits ten milliseconds after reset or resume before transfers.
// [R6] Transfers ignored during the ten millisecond recovery, accepted afterward.
// [R7] Address assignment must finish its status stage within fifty milliseconds.
// [R8] Address status completes on sending zero-length status packet or its acknowledge.
// [R9] New address answered, old one dropped, within two milliseconds of status.
// [R10] Requests without data stage finish status within fifty milliseconds.
// [R11] IN data: 500 ms per packet, then status within 50 ms.
// [R12] OUT data plus status within five seconds of device-side time.
// [R13] Class requests share the standard deadlines.
// [R14] Speed fixed after reset; only current-speed descriptors offered.
// [R15] Dual-speed devices answer qualifier and other-speed configuration reads.
// [R16] Dual-speed devices report version 0200H.
// [R17] Below version 0200H, other-speed descriptor reads are request errors.
// [R18] Host does not send other-speed reads to older-version devices.
// [R19] Request errors stall the next data transaction, else the status stage.
// [R20] Requests arrive as eight setup bytes on the control pipe.
// [R21] Setup bytes: bitmap, code, value, index, length; words little-endian.
// [R22] Bitmap: direction bit 7, type bits 6..5, recipient bits 4..0.
// [R23] Direction ignored when the length word is zero.
// [R24] Never send more IN bytes than the requested length.
// [R25] New address is latched only after its status stage completes.
module ucrh_top #(
   parameter int TICK_CYCLES = ucrh_pkg::TICK_CYCLES,
   parameter int MAX_PKT = ucrh_pkg::MAX_PKT
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Events from the serial engine.
   input wire logic recovery_start,
   input wire logic high_speed,
   input wire logic setup_byte_valid,
   input wire logic [7:0] setup_byte,
   input wire logic setup_ack_sent,
   input wire logic in_pkt_sent,
   input wire logic [10:0] in_pkt_len,
   input wire logic out_pkt_rcvd,
   input wire logic status_done,
   input wire logic token_valid,
   input wire logic [6:0] token_addr,
   // Results to the serial engine.
   output logic accept_xfer,
   output logic addr_match,
   output logic [6:0] dev_addr,
   output logic speed_hs,
   output logic req_valid,
   output logic status_ready,
   output logic stall_data,
   output logic stall_status,
   output logic [15:0] in_allow,
   output logic overrun
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ucrh_pkg::ucrh_state_t state;
      logic [2:0] byte_idx;
      logic [63:0] setup;
      logic [14:0] tick_cnt;
      logic tick;
      logic [12:0] ms_cnt;
      logic [12:0] ms_limit;
      logic timed;
      logic hs;
      logic [6:0] dev_addr;
      logic [6:0] pend_addr;
      logic addr_pend;
      logic fw_done;
      logic fw_err;
      logic dual;
      logic [15:0] bcd;
      logic overrun;
      logic [15:0] remain;
      logic [15:0] allow;
      logic stall_data;
      logic stall_status;
      logic req_valid;
      logic accept;
      logic addr_match;
      logic a_wr;
      logic a_rd;
      logic [7:0] a_addr;
      logic [31:0] hrdata;
      logic hreadyout;
   } ucrh_regs_t;

   ucrh_regs_t r;
   ucrh_regs_t next_r;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // Setup words are little-endian; wLength sits in bytes 6 and 7.
   function automatic logic [15:0] ucrh_len(input logic [63:0] s);
      ucrh_len = {s[63:56], s[55:48]}; // [R21]
   endfunction

   function automatic logic ucrh_is_setaddr(input logic [63:0] s);
      ucrh_is_setaddr = (s[6:5] == ucrh_pkg::TYPE_STD) && (s[4:0] == 5'h00) &&
                        (s[15:8] == ucrh_pkg::REQ_SET_ADDR); // [R22]
   endfunction

   // Reserved type or recipient, or an other-speed read that this device
   // cannot serve, is rejected in hardware without bothering firmware.
   function automatic logic ucrh_hw_err(input logic [63:0] s, input logic [15:0] bcd, input logic dual);
      logic other;
      other = (s[6:5] == ucrh_pkg::TYPE_STD) && (s[15:8] == ucrh_pkg::REQ_GET_DESC) &&
              ((s[31:24] == ucrh_pkg::DESC_QUAL) || (s[31:24] == ucrh_pkg::DESC_OTHER));
      ucrh_hw_err = (s[6:5] == ucrh_pkg::TYPE_RSVD) || (s[4:0] > ucrh_pkg::RCPT_MAX) || // [R22]
                    (other && ((bcd < ucrh_pkg::BCD_DUAL) || !dual)); // [R17] [R15]
   endfunction

   logic in_phase;
   logic err_now;
   logic [15:0] sent;
   assign in_phase = (r.state == ucrh_pkg::S_DIN);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // One process computes every register; the bus, the request sequencer
   // and the timers all read the same snapshot, so no ordering races.
   always_comb begin
      next_r = r;
      err_now = 1'b0;
      sent = 16'h0000;
      next_r.req_valid = 1'b0;
      next_r.tick = 1'b0;

      // Millisecond tick divider.
      if (r.tick_cnt == 15'(TICK_CYCLES - 1)) begin
         next_r.tick_cnt = 15'h0000;
         next_r.tick = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 15'h0001;
      end

      // Deadline counter runs in timed phases; during OUT data it only runs
      // while the device itself holds off, so host pauses extend the limit.
      if (r.tick && r.timed && !(r.state == ucrh_pkg::S_DOUT && r.fw_done)) begin // [R12]
         next_r.ms_cnt = r.ms_cnt + 13'h0001;
      end

      // Register write in the data phase.
      if (r.a_wr) begin
         case (r.a_addr)
            ucrh_pkg::A_CTRL: begin
               if (hwdata[ucrh_pkg::CTRL_DONE] && r.timed) begin
                  next_r.fw_done = 1'b1; // [R3]
               end
               if (hwdata[ucrh_pkg::CTRL_ERR] && r.timed) begin
                  err_now = 1'b1;
               end
            end
            ucrh_pkg::A_CONFIG: begin
               next_r.dual = hwdata[ucrh_pkg::CFG_DUAL];
               next_r.bcd = hwdata[ucrh_pkg::CFG_BCD_LSB +: 16]; // [R16]
            end
            ucrh_pkg::A_STATUS: begin
               if (hwdata[ucrh_pkg::ST_OVR]) begin
                  next_r.overrun = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Request sequencer.
      case (r.state)
         ucrh_pkg::S_RECOV: begin
            // Transfers are ignored until ten ticks have passed.
            if (r.tick) begin
               next_r.ms_cnt = r.ms_cnt + 13'h0001;
            end
            if (r.ms_cnt >= ucrh_pkg::T_RECOV_MS) begin // [R6]
               next_r.state = ucrh_pkg::S_IDLE;
               next_r.accept = 1'b1;
               next_r.ms_cnt = 13'h0000;
            end
         end
         ucrh_pkg::S_WAIT_ACK: begin
            if (setup_ack_sent) begin // [R1]
               next_r.timed = 1'b1;
               next_r.ms_cnt = 13'h0000;
               next_r.remain = ucrh_len(r.setup);
               if (ucrh_is_setaddr(r.setup)) begin
                  next_r.pend_addr = r.setup[22:16];
                  next_r.addr_pend = 1'b1;
               end
               if (ucrh_len(r.setup) == 16'h0000) begin
                  next_r.state = ucrh_pkg::S_PROC; // [R23]
                  next_r.ms_limit = ucrh_pkg::T_NODATA_MS; // [R10] [R7] [R13]
               end else if (r.setup[7]) begin
                  next_r.state = ucrh_pkg::S_DIN;
                  next_r.ms_limit = ucrh_pkg::T_IN_PKT_MS; // [R11]
               end else begin
                  next_r.state = ucrh_pkg::S_DOUT;
                  next_r.ms_limit = ucrh_pkg::T_OUT_MS; // [R12] [R4]
               end
               if (ucrh_hw_err(r.setup, r.bcd, r.dual)) begin
                  err_now = 1'b1;
               end else begin
                  next_r.req_valid = 1'b1;
               end
            end
         end
         ucrh_pkg::S_DIN: begin
            if (in_pkt_sent) begin
               // Clamp to what is left so the count never wraps.
               sent = (16'(in_pkt_len) > r.remain) ? r.remain : 16'(in_pkt_len);
               next_r.remain = r.remain - sent; // [R24]
               next_r.ms_cnt = 13'h0000;
               if ((r.remain == sent) || (in_pkt_len < 11'(MAX_PKT))) begin
                  next_r.state = ucrh_pkg::S_STATUS;
                  next_r.ms_limit = ucrh_pkg::T_STATUS_MS; // [R11]
               end
            end
         end
         ucrh_pkg::S_DOUT: begin
            if (out_pkt_rcvd && (r.remain != 16'h0000)) begin
               next_r.remain = r.remain - 16'h0001;
            end
         end
         default: begin
         end
      endcase

      // Status completion ends the request; a pending address takes effect
      // only now, so the old address keeps answering until then.
      if (status_done && r.fw_done && r.timed) begin // [R2] [R8]
         next_r.state = ucrh_pkg::S_IDLE;
         next_r.timed = 1'b0;
         next_r.fw_done = 1'b0;
         if (r.addr_pend) begin
            next_r.dev_addr = r.pend_addr; // [R25] [R9]
            next_r.addr_pend = 1'b0;
         end
      end

      // Request error: stall the data stage when one exists, else status.
      if (err_now) begin // [R19]
         next_r.state = ucrh_pkg::S_IDLE;
         next_r.timed = 1'b0;
         next_r.fw_done = 1'b0;
         next_r.addr_pend = 1'b0;
         next_r.req_valid = 1'b0;
         if ((r.state == ucrh_pkg::S_WAIT_ACK && ucrh_len(r.setup) != 16'h0000) ||
             r.state == ucrh_pkg::S_DIN || r.state == ucrh_pkg::S_DOUT) begin
            next_r.stall_data = 1'b1;
         end else begin
            next_r.stall_status = 1'b1;
         end
      end

      // Setup bytes: a new setup overrides whatever was in progress, except during recovery, where its bytes are ignored.
      if (setup_byte_valid && r.state != ucrh_pkg::S_RECOV) begin // [R20]
         next_r.setup[{r.byte_idx, 3'b000} +: 8] = setup_byte; // [R21]
         next_r.byte_idx = r.byte_idx + 3'h1;
         next_r.stall_data = 1'b0;
         next_r.stall_status = 1'b0;
         // Any byte aborts the open request, so stale counts never outlive it.
         next_r.timed = 1'b0;
         next_r.fw_done = 1'b0;
         next_r.addr_pend = 1'b0;
         next_r.state = (r.byte_idx == 3'h7) ? ucrh_pkg::S_WAIT_ACK : ucrh_pkg::S_IDLE;
      end

      // Overrun is sticky; a deadline hit in the clearing cycle still sets it.
      if (r.timed && r.ms_cnt >= r.ms_limit) begin // [R4]
         next_r.overrun = 1'b1;
      end

      // Bus reset or resume end restarts recovery and fixes the speed.
      if (recovery_start) begin // [R5] [R14]
         next_r.state = ucrh_pkg::S_RECOV;
         next_r.hs = high_speed;
         next_r.accept = 1'b0;
         next_r.ms_cnt = 13'h0000;
         next_r.timed = 1'b0;
         next_r.fw_done = 1'b0;
         next_r.byte_idx = 3'h0;
         next_r.addr_pend = 1'b0;
         next_r.stall_data = 1'b0;
         next_r.stall_status = 1'b0;
      end

      // Token address match, gated by recovery.
      next_r.addr_match = token_valid && r.accept && (token_addr == r.dev_addr); // [R6] [R9]

      // AHB address phase capture and read data.
      next_r.a_wr = hsel && hready && htrans[1] && hwrite;
      next_r.a_rd = hsel && hready && htrans[1] && !hwrite;
      next_r.a_addr = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            ucrh_pkg::A_SETUP_LO: next_r.hrdata = r.setup[31:0];
            ucrh_pkg::A_SETUP_HI: next_r.hrdata = r.setup[63:32];
            ucrh_pkg::A_CTRL: next_r.hrdata = {30'h0000_0000, 1'b0, r.fw_done};
            ucrh_pkg::A_CONFIG: next_r.hrdata = {r.bcd, 15'h0000, r.dual};
            ucrh_pkg::A_STATUS: next_r.hrdata = {9'h000, r.dev_addr, 7'h00, r.overrun, r.stall_status,
                                                 r.stall_data, !r.accept, r.hs, 1'b0, r.state};
            default: next_r.hrdata = 32'h0000_0000;
         endcase
      end
      // Registered IN allowance, zero outside the IN data stage.
      next_r.allow = (next_r.state == ucrh_pkg::S_DIN) ? next_r.remain : 16'h0000; // [R24]
      next_r.hreadyout = 1'b1;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reset puts the device in recovery at the default address.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.state <= ucrh_pkg::S_RECOV;
         r.bcd <= ucrh_pkg::BCD_RESET;
         r.hreadyout <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // All outputs except hresp, which is tied to zero, come straight from the state register.
   assign hreadyout = r.hreadyout;
   assign hresp = 1'b0;
   assign hrdata = r.hrdata;
   assign accept_xfer = r.accept;
   assign addr_match = r.addr_match;
   assign dev_addr = r.dev_addr;
   assign speed_hs = r.hs;
   assign req_valid = r.req_valid;
   assign status_ready = r.fw_done; // [R2]
   assign stall_data = r.stall_data;
   assign stall_status = r.stall_status;
   assign in_allow = r.allow; // [R24]
   assign overrun = r.overrun;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking ucrh_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence ucrh_setup_end;
      setup_byte_valid && r.byte_idx == 3'h7 && !recovery_start && r.state != ucrh_pkg::S_RECOV;
   endsequence

   sequence ucrh_ack_clean;
      setup_ack_sent && r.state == ucrh_pkg::S_WAIT_ACK && !ucrh_hw_err(r.setup, r.bcd, r.dual) &&
      !setup_byte_valid && !recovery_start && !(r.a_wr && r.a_addr == ucrh_pkg::A_CTRL && hwdata[1]);
   endsequence

   a_req_after_ack: assert property (ucrh_setup_end ##[1:8] ucrh_ack_clean |=> req_valid) // [R1]
      else $error("request not raised after setup handshake");
   a_status_gate: assert property ($rose(status_ready) |-> $past(r.a_wr) && r.state != ucrh_pkg::S_IDLE) // [R2]
      else $error("status offered without firmware completion");
   a_recov_block: assert property (recovery_start |=> !accept_xfer [*8]) // [R6]
      else $error("transfers accepted during recovery");
   a_addr_commit: assert property ($changed(dev_addr) |-> $past(status_done) && $past(r.addr_pend)) // [R25]
      else $error("address changed outside status completion");
   a_addr_switch: assert property (status_done && r.fw_done && r.timed && r.addr_pend && !recovery_start
                                   |=> dev_addr == $past(r.pend_addr)) // [R9]
      else $error("new address not taken at status completion");
   a_in_limit: assert property (in_phase |-> in_allow <= ucrh_len(r.setup)) // [R24]
      else $error("IN allowance exceeds requested length");
   a_stall_excl: assert property (!(stall_data && stall_status)) // [R19]
      else $error("both stall kinds raised");
   a_speed_fixed: assert property (!recovery_start |=> speed_hs == $past(speed_hs)) // [R14]
      else $error("speed changed outside reset");
   a_overrun_set: assert property (r.timed && r.ms_cnt >= r.ms_limit |=> overrun) // [R4]
      else $error("deadline overrun not flagged");
   a_other_speed: assert property (setup_ack_sent && r.state == ucrh_pkg::S_WAIT_ACK && !recovery_start &&
                                   r.bcd < ucrh_pkg::BCD_DUAL && r.setup[15:0] == 16'h0680 &&
                                   r.setup[31:24] == ucrh_pkg::DESC_OTHER |=> stall_data || stall_status) // [R17]
      else $error("other-speed read not stalled");

endmodule
